// [hw/sld_pkg.sv]
// Constants, carriers and lane packing helpers for the lane data port
package sld_pkg;

  localparam int LANE_COUNT = 10;
  localparam int WIDE_LANES = 4;
  localparam int NARROW_LANES = LANE_COUNT - WIDE_LANES;
  localparam int WIDE_W = 80;
  localparam int NARROW_W = 32;
  localparam int EXT_W = 16;
  localparam int MAIN_W = 64;

  typedef logic [WIDE_W-1:0] sld_word_t;

  // Lane-side buses: 16-bit extension and 64-bit main groups on lanes 0-3
  typedef struct packed {
    logic [WIDE_LANES-1:0][EXT_W-1:0]      ext;
    logic [WIDE_LANES-1:0][MAIN_W-1:0]     main;
    logic [NARROW_LANES-1:0][NARROW_W-1:0] narrow;
  } sld_lane_bus_t;

  // Whole state of the port
  typedef struct packed {
    logic [LANE_COUNT-1:0]             txc_s1;
    logic [LANE_COUNT-1:0]             txc_s2;
    logic [LANE_COUNT-1:0]             txc_s3;
    logic [LANE_COUNT-1:0]             rxc_s1;
    logic [LANE_COUNT-1:0]             rxc_s2;
    logic [LANE_COUNT-1:0]             rxc_s3;
    logic [LANE_COUNT-1:0]             rst_s1;
    logic [LANE_COUNT-1:0]             rst_s2;
    sld_lane_bus_t                     rxd_s1;
    sld_lane_bus_t                     rxd_s2;
    logic [LANE_COUNT-1:0][WIDE_W-1:0] rx_data;
    logic [LANE_COUNT-1:0]             rx_valid;
    sld_lane_bus_t                     tx_bus;
    logic [LANE_COUNT-1:0]             tx_take;
  } sld_state_t;

  localparam sld_state_t STATE_RST = '0;
  localparam sld_word_t NARROW_MASK = 80'h0000_0000_0000_FFFF_FFFF;

  // Gather one lane of a lane bus into an 80-bit word
  function automatic sld_word_t sld_unpack(sld_lane_bus_t b, int lane,
                                           logic wide);
    sld_word_t w;
    w = '0;
    if (lane < WIDE_LANES) begin
      w = {b.ext[lane], b.main[lane]};
    end else begin
      w[NARROW_W-1:0] = b.narrow[lane-WIDE_LANES];
    end
    if (!wide) begin
      w = w & NARROW_MASK;
    end
    return w;
  endfunction

  // Place an 80-bit word onto one lane of a lane bus
  function automatic sld_lane_bus_t sld_pack(sld_lane_bus_t b, int lane,
                                             sld_word_t w, logic wide);
    sld_lane_bus_t r;
    sld_word_t     m;
    r = b;
    m = wide ? w : (w & NARROW_MASK);
    if (lane < WIDE_LANES) begin
      r.ext[lane]  = m[WIDE_W-1:MAIN_W];
      r.main[lane] = m[MAIN_W-1:0];
    end else begin
      r.narrow[lane-WIDE_LANES] = m[NARROW_W-1:0];
    end
    return r;
  endfunction

endpackage

// [hw/sld_lane_port.sv]
// Ten-lane transceiver data port with per-lane clocks and receive resets
`timescale 1ns/1ps

// Function
// R1 - Ten separate transmit lane buses are driven, one per lane.
// R2 - A lane bus is 80 bits in four-lane mode and 32 bits in ten-lane mode.
// R3 - Lanes 0-3 carry either width while lanes 4-9 always carry 32 bits.
// R4 - In ten-lane mode only the low 32 bits of lanes 0-3 carry data.
// R5 - Each 80-bit lane is split into a 16-bit and a 64-bit group.
// R6 - Receive data is sampled at the rising edge of that lane's clock.
// R7 - Each lane's high receive reset holds that lane's receive logic idle.
// R8 - The transceiver raises a lane reset while its clock is off frequency.
// R9 - The transceiver holds the reset until its start-up ends and is stable.
// R10 - Ten receive lane buses are taken with the same widths and split.
// R11 - The extension group holds word bits 79:64, the main group bits 63:0.
module sld_lane_port
  import sld_pkg::*;
(
  input  wire logic                              i_core_clk,
  input  wire logic                              i_rst_b,
  input  wire logic                              i_caui4_mode,
  input  wire logic [LANE_COUNT-1:0]             i_tx_lane_clock,
  input  wire logic [LANE_COUNT-1:0][WIDE_W-1:0] i_tx_user_data,
  output logic      [LANE_COUNT-1:0]             o_tx_user_ready,
  output sld_lane_bus_t                          o_tx_lane_bus,
  input  wire logic [LANE_COUNT-1:0]             i_rx_lane_recovered_clock,
  input  wire logic [LANE_COUNT-1:0]             i_rx_lane_reset,
  input  wire sld_lane_bus_t                     i_rx_lane_bus,
  output logic      [LANE_COUNT-1:0][WIDE_W-1:0] o_rx_user_data,
  output logic      [LANE_COUNT-1:0]             o_rx_user_valid
);

  sld_state_t q;
  sld_state_t d;

  always_comb begin
    d = q;
    d.txc_s1 = i_tx_lane_clock;
    d.txc_s2 = q.txc_s1;
    d.txc_s3 = q.txc_s2;
    d.rxc_s1 = i_rx_lane_recovered_clock;
    d.rxc_s2 = q.rxc_s1;
    d.rxc_s3 = q.rxc_s2;
    d.rst_s1 = i_rx_lane_reset;
    d.rst_s2 = q.rst_s1;
    d.rxd_s1 = i_rx_lane_bus;
    d.rxd_s2 = q.rxd_s1;
    for (int l = 0; l < LANE_COUNT; l++) begin
      // R1 R3 R5 transmit lane update
      d.tx_take[l] = q.txc_s2[l] & ~q.txc_s3[l];
      if (d.tx_take[l]) begin
        // R2 R4 R11 width and group placement
        d.tx_bus = sld_pack(d.tx_bus, l, i_tx_user_data[l], i_caui4_mode);
      end
      // R7 lane held in reset
      if (q.rst_s2[l]) begin
        d.rx_valid[l] = 1'b0;
        d.rx_data[l]  = '0;
      end else begin
        // R6 R10 sample on recovered edge
        d.rx_valid[l] = q.rxc_s2[l] & ~q.rxc_s3[l];
        if (d.rx_valid[l]) begin
          d.rx_data[l] = sld_unpack(q.rxd_s2, l, i_caui4_mode);
        end
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  assign o_tx_user_ready = q.tx_take;
  assign o_tx_lane_bus   = q.tx_bus;
  assign o_rx_user_data  = q.rx_data;
  assign o_rx_user_valid = q.rx_valid;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  property p_tx_main_wide;
    (q.txc_s2[0] && !q.txc_s3[0] && i_caui4_mode) |=>
      o_tx_lane_bus.main[0] == $past(i_tx_user_data[0][63:0]);
  endproperty
  a_tx_main_wide: assert property (p_tx_main_wide) // R1 R5
    else $error("lane 0 main group not loaded at tx edge");

  property p_tx_ext_map;
    (q.txc_s2[2] && !q.txc_s3[2] && i_caui4_mode) |=>
      o_tx_user_ready[2] &&
      o_tx_lane_bus.ext[2] == $past(i_tx_user_data[2][79:64]);
  endproperty
  a_tx_ext_map: assert property (p_tx_ext_map) // R11
    else $error("lane 2 extension group mismapped");

  property p_tx_narrow;
    (q.txc_s2[0] && !q.txc_s3[0] && !i_caui4_mode) |=>
      o_tx_lane_bus.ext[0] == '0 && o_tx_lane_bus.main[0][63:32] == '0;
  endproperty
  a_tx_narrow: assert property (p_tx_narrow) // R2 R4
    else $error("upper bits of lane 0 not idle in ten-lane mode");

  property p_tx_lane9;
    o_tx_user_ready[9] |->
      o_tx_lane_bus.narrow[5] == $past(i_tx_user_data[9][31:0]);
  endproperty
  a_tx_lane9: assert property (p_tx_lane9) // R3
    else $error("lane 9 narrow bus not loaded");

  property p_rx_sample;
    (q.rxc_s2[0] && !q.rxc_s3[0] && !q.rst_s2[0] && i_caui4_mode) |=>
      o_rx_user_valid[0] &&
      o_rx_user_data[0] == {$past(q.rxd_s2.ext[0]), $past(q.rxd_s2.main[0])};
  endproperty
  a_rx_sample: assert property (p_rx_sample) // R6 R10
    else $error("lane 0 receive word not captured at clock edge");

  property p_rx_reset;
    q.rst_s2[3] |=> !o_rx_user_valid[3] && o_rx_user_data[3] == '0;
  endproperty
  a_rx_reset: assert property (p_rx_reset) // R7
    else $error("lane 3 receive active while in reset");

  property p_rx_reset_pin;
    i_rx_lane_reset[5] [*3] |=> !o_rx_user_valid[5];
  endproperty
  a_rx_reset_pin: assert property (p_rx_reset_pin) // R7
    else $error("lane 5 delivered data during held reset");

  property p_rx_pulse;
    o_rx_user_valid[9] |=> !o_rx_user_valid[9];
  endproperty
  a_rx_pulse: assert property (p_rx_pulse) // R10
    else $error("lane 9 receive valid longer than one cycle");

  property p_rx_narrow;
    (!i_caui4_mode && o_rx_user_valid[1]) |-> o_rx_user_data[1][79:32] == '0;
  endproperty
  a_rx_narrow: assert property (p_rx_narrow) // R4
    else $error("lane 1 upper bits set in ten-lane mode");

  // Transmit ready pulse and lane hold
  property p_tx_ready_pulse;
    o_tx_user_ready[0] |=>
      !o_tx_user_ready[0];
  endproperty
  a_tx_ready_pulse: assert property (p_tx_ready_pulse) // R1
    else $error("lane 0 transmit ready longer than one cycle");

  property p_tx_hold;
    !o_tx_user_ready[4] |->
      o_tx_lane_bus.narrow[0] == $past(o_tx_lane_bus.narrow[0]);
  endproperty
  a_tx_hold: assert property (p_tx_hold) // R1
    else $error("lane 4 bus changed without a take");

  property p_tx_lane5;
    o_tx_user_ready[5] |->
      o_tx_lane_bus.narrow[1] == $past(i_tx_user_data[5][31:0]);
  endproperty
  a_tx_lane5: assert property (p_tx_lane5) // R3
    else $error("lane 5 narrow bus not loaded");

  property p_tx_lane3_wide;
    (o_tx_user_ready[3] && i_caui4_mode) |->
      {o_tx_lane_bus.ext[3], o_tx_lane_bus.main[3]} ==
        $past(i_tx_user_data[3]);
  endproperty
  a_tx_lane3_wide: assert property (p_tx_lane3_wide) // R2 R5
    else $error("lane 3 wide word not loaded");

  property p_tx_ext_narrow;
    (o_tx_user_ready[1] && !i_caui4_mode) |->
      o_tx_lane_bus.ext[1] == '0 && o_tx_lane_bus.main[1][63:32] == '0;
  endproperty
  a_tx_ext_narrow: assert property (p_tx_ext_narrow) // R4
    else $error("lane 1 upper bits set in ten-lane mode");

  // Receive hold, narrow lanes and reset
  property p_rx_hold;
    (!o_rx_user_valid[6] && !$past(q.rst_s2[6])) |->
      o_rx_user_data[6] == $past(o_rx_user_data[6]);
  endproperty
  a_rx_hold: assert property (p_rx_hold) // R10
    else $error("lane 6 receive data changed without capture");

  property p_rx_lane7_narrow;
    o_rx_user_valid[7] |->
      o_rx_user_data[7][79:32] == '0;
  endproperty
  a_rx_lane7_narrow: assert property (p_rx_lane7_narrow) // R3
    else $error("lane 7 upper receive bits set");

  property p_rx_lane8;
    (q.rxc_s2[8] && !q.rxc_s3[8] && !q.rst_s2[8]) |=>
      o_rx_user_valid[8] &&
      o_rx_user_data[8] == {48'h0, $past(q.rxd_s2.narrow[4])};
  endproperty
  a_rx_lane8: assert property (p_rx_lane8) // R6 R10
    else $error("lane 8 receive word not captured at clock edge");

  property p_rx_reset_data;
    i_rx_lane_reset[0] [*3] |=>
      o_rx_user_data[0] == '0;
  endproperty
  a_rx_reset_data: assert property (p_rx_reset_data) // R7
    else $error("lane 0 receive data not cleared in reset");

  property p_rx_pulse4;
    o_rx_user_valid[4] |=>
      !o_rx_user_valid[4];
  endproperty
  a_rx_pulse4: assert property (p_rx_pulse4) // R10
    else $error("lane 4 receive valid longer than one cycle");

  // Coverage
  c_tx_wide: cover property (i_caui4_mode && o_tx_user_ready[0]);
  c_rx_narrow: cover property (!i_caui4_mode && o_rx_user_valid[2]);
  c_tx_narrow: cover property (!i_caui4_mode && o_tx_user_ready[3]);
  c_rx_take: cover property (o_rx_user_valid[0] ##[1:20] o_rx_user_valid[0]);
  c_rx_reset: cover property (q.rst_s2[4] ##1 !q.rst_s2[4]);

endmodule // sld_lane_port

// [tb/sld_xcvr_model.sv]
// Behavioural model of the ten transceiver lanes
`timescale 1ns/1ps
module sld_xcvr_model
  import sld_pkg::*;
(
  input  wire logic           i_run,
  input  wire sld_lane_bus_t  i_rx_src,
  output logic [LANE_COUNT-1:0] o_clk,
  output logic [LANE_COUNT-1:0] o_rx_reset,
  output sld_lane_bus_t         o_rx_bus
);
  logic clk  = 1'b0;
  int   lock = 0;
  initial o_rx_bus = '0;
  assign o_clk = {LANE_COUNT{clk}};
  assign o_rx_reset = {LANE_COUNT{lock < 4}};
  initial begin
    #7;
    forever begin
      #80;
      if (i_run) begin
        clk = ~clk;
        if (clk && lock < 4) lock = lock + 1;
        if (!clk) o_rx_bus = i_rx_src;
      end else begin
        clk = 1'b0;
        lock = 0;
        o_rx_bus = ~o_rx_bus;
      end
    end
  end
endmodule // sld_xcvr_model

// [tb/sld_lane_port_bench.sv]
// Self-checking bench for the ten-lane data port
`timescale 1ns/1ps
module sld_lane_port_bench
  import sld_pkg::*;
;
  logic i_core_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic mode = 1'b1;
  logic run = 1'b0;
  logic [LANE_COUNT-1:0][WIDE_W-1:0] tx_d = '0;
  logic [LANE_COUNT-1:0][WIDE_W-1:0] rx_d;
  logic [LANE_COUNT-1:0] lclk, rx_rst, tx_rdy, rx_vld, seen;
  sld_lane_bus_t tx_bus, rx_bus;
  sld_lane_bus_t rx_src = '0;
  int n_fail = 0;
  int comparisons = 0;
  always #10 i_core_clk = ~i_core_clk;
  sld_xcvr_model xcvr_u (.i_run(run), .i_rx_src(rx_src), .o_clk(lclk),
    .o_rx_reset(rx_rst), .o_rx_bus(rx_bus));
  sld_lane_port dut_u (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
    .i_caui4_mode(mode), .i_tx_lane_clock(lclk), .i_tx_user_data(tx_d),
    .o_tx_user_ready(tx_rdy), .o_tx_lane_bus(tx_bus),
    .i_rx_lane_recovered_clock(lclk), .i_rx_lane_reset(rx_rst),
    .i_rx_lane_bus(rx_bus), .o_rx_user_data(rx_d),
    .o_rx_user_valid(rx_vld));
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [WIDE_W-1:0] got,
                       input logic [WIDE_W-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_ev(input bit rx);
    for (int i = 0; i < 80; i++) begin
      @(posedge i_core_clk);
      #1;
      if ((rx ? rx_vld[0] : tx_rdy[0]) === 1'b1) return;
    end
    n_fail++;
    $display("CHECK FAILED t=%0t no handshake", $time);
    print_verdict();
  endtask
  task automatic tx_case(input int k);
    logic [WIDE_W-1:0] w, got, e;
    @(posedge i_core_clk);
    for (int l = 0; l < LANE_COUNT; l++) tx_d[l] <= {10{8'(k * 16 + l)}};
    wait_ev(0);
    wait_ev(0);
    check(80'(tx_rdy), 80'(10'h3FF));
    for (int l = 0; l < LANE_COUNT; l++) begin
      w = tx_d[l];
      if (l < WIDE_LANES) got = {tx_bus.ext[l], tx_bus.main[l]};
      else got = {48'h0, tx_bus.narrow[l - WIDE_LANES]};
      e = (l < WIDE_LANES && mode) ? w : {48'h0, w[31:0]};
      check(got, e);
    end
  endtask
  task automatic rx_case(input int k);
    logic [WIDE_W-1:0] e;
    @(posedge i_core_clk);
    for (int i = 0; i < 64; i++) rx_src[i * 8 +: 8] <= 8'(i + k);
    wait_ev(1);
    wait_ev(1);
    check(80'(rx_vld), 80'(10'h3FF));
    for (int l = 0; l < LANE_COUNT; l++) begin
      if (l < WIDE_LANES) e = {rx_src.ext[l], rx_src.main[l]};
      else e = {48'h0, rx_src.narrow[l - WIDE_LANES]};
      if (!mode) e[79:32] = '0;
      check(rx_d[l], e);
    end
  endtask
  task automatic reset_case();
    @(posedge i_core_clk);
    run <= 1'b0;
    // Let a capture already in flight drain
    repeat (10) @(posedge i_core_clk);
    seen = '0;
    repeat (24) begin
      @(posedge i_core_clk);
      seen = seen | rx_vld;
    end
    #1;
    check(80'(seen), '0);
    check(rx_d[0], '0);
    @(posedge i_core_clk);
    run <= 1'b1;
    rx_case(9);
  endtask
  initial begin
    repeat (5) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    run <= 1'b1;
    tx_case(1);
    rx_case(2);
    reset_case();
    @(posedge i_core_clk);
    i_rst_b <= 1'b0;
    mode <= 1'b0;
    repeat (5) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    tx_case(3);
    rx_case(4);
    print_verdict();
  end
endmodule // sld_lane_port_bench
